// ### logic/hspc_pkg.sv
// Package for the host sleep power control block: register layout, timing and types
package hspc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SLEEP_CONTROL_OFFSET = 8'h17;
  localparam int SLEEP_REQUEST_BIT = 7;
  localparam int SLEEP_RESET_ENABLE_BIT = 6;
  localparam int EXT2_EDGE_POLARITY_BIT = 5;
  localparam int EXT1_EDGE_POLARITY_BIT = 4;
  localparam int SLEEP_OCCURRED_FLAG_BIT = 3;
  localparam int SLEEP_TIMEOUT_MSB = 2;
  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
  localparam logic [2:0] PIN2_SELECT_SLEEP = 3'h6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int TICK_PERIOD_US = 7800;
  localparam longint TICK_CYCLES_L = longint'(CLK_FREQ_HZ) * TICK_PERIOD_US / 1_000_000;
  localparam int TICK_CYCLES = int'(TICK_CYCLES_L);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    HSPC_RUN = 2'b00,
    HSPC_WAIT = 2'b01,
    HSPC_SLEEP = 2'b11
  } hspc_state_e;

  // Enables and conditions that decide whether a sleep request may take hold
  typedef struct packed {
    logic clock_halt;
    logic alarm_irq_enable;
    logic countdown_irq_enable;
    logic countdown_run_enable;
    logic first_ext_wake_enable;
    logic second_ext_wake_enable;
    logic watchdog_period_nonzero;
    logic watchdog_steering;
    logic irq_pending;
  } hspc_guard_s;

  // Enabled interrupt requests from the sources around the block
  typedef struct packed {
    logic alarm;
    logic countdown;
    logic watchdog;
    logic battery_low;
    logic autocal_fail;
    logic osc_fail;
  } hspc_irq_s;

endpackage

// ### logic/hspc_top.sv
// Sleep control state machine with host power switch and host reset
`timescale 1ns/1ps
`default_nettype none
module hspc_top
  import hspc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock, reset and power valid
  input wire logic CLK,
  input wire logic RESET,
  input wire logic POWER_VALID,
  // Register access port
  input wire logic REG_WRITE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Configuration from neighbouring registers
  input wire hspc_guard_s GUARD,
  input wire logic [2:0] PIN2_OUTPUT_SELECT,
  input wire logic LOW_RES_SWITCH_ENABLE,
  input wire logic STATIC_OUT_BIT,
  // Interrupt sources
  input wire hspc_irq_s IRQ,
  input wire logic EXT_INPUT_PIN,
  input wire logic WATCHDOG_INPUT_PIN,
  output logic FIRST_EXTERNAL_IRQ,
  output logic SECOND_EXTERNAL_IRQ,
  // Host control pins
  output logic HOST_RESET_N,
  output logic HOST_POWER_SIGNAL,
  output logic POWER_SWITCH_PIN_O,
  output logic POWER_SWITCH_PIN_OE,
  output logic [1:0] SLEEP_STATE
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (TICK_CYCLES_P < 2) begin : g_bad_tick
    $error("TICK_CYCLES_P must be at least 2");
  end

  // ****************************************
  // Declarations
  // ****************************************
  hspc_state_e state, next_state;
  logic sleep_request, sleep_reset_enable, ext2_edge_polarity, ext1_edge_polarity;
  logic sleep_occurred_flag;
  logic [2:0] sleep_timeout_count, delay_count;
  logic [31:0] tick_div;
  logic tick;
  logic [1:0] ext_sync, wdi_sync;
  logic ext_prev, wdi_prev;
  logic pv_meta, pv_sync;
  wire reg_hit = REG_WRITE && (REG_ADDR == SLEEP_CONTROL_OFFSET);
  wire req_write = reg_hit && REG_WDATA[SLEEP_REQUEST_BIT];
  wire flag_write_clear = reg_hit && !REG_WDATA[SLEEP_OCCURRED_FLAG_BIT];
  wire [2:0] new_timeout = REG_WDATA[SLEEP_TIMEOUT_MSB:0];

  // ****************************************
  // Input synchronisers and edge detection
  // ****************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ext_sync <= 2'h0;
      wdi_sync <= 2'h0;
      ext_prev <= 1'b0;
      wdi_prev <= 1'b0;
      pv_meta <= 1'b0;
      pv_sync <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], EXT_INPUT_PIN};
      wdi_sync <= {wdi_sync[0], WATCHDOG_INPUT_PIN};
      ext_prev <= ext_sync[1];
      wdi_prev <= wdi_sync[1];
      pv_meta <= POWER_VALID;
      pv_sync <= pv_meta;
    end
  end

  wire ext_rise = ext_sync[1] && !ext_prev;
  wire ext_fall = !ext_sync[1] && ext_prev;
  wire wdi_rise = wdi_sync[1] && !wdi_prev;
  wire wdi_fall = !wdi_sync[1] && wdi_prev;
  wire ext1_edge = ext1_edge_polarity ? ext_rise : ext_fall;
  wire ext2_edge = ext2_edge_polarity ? wdi_rise : wdi_fall;

  // ****************************************
  // Wake trigger and request guard
  // ****************************************
  // Edge events are one-cycle pulses so they wake but do not count as pending
  wire ext1_req = ext1_edge && GUARD.first_ext_wake_enable;
  wire ext2_req = ext2_edge && GUARD.second_ext_wake_enable;
  wire wake_trigger = IRQ.alarm | IRQ.countdown | IRQ.watchdog | ext1_req | ext2_req
                      | IRQ.battery_low | IRQ.autocal_fail | IRQ.osc_fail;
  wire wake_enabled = GUARD.alarm_irq_enable
                      || (GUARD.countdown_irq_enable && GUARD.countdown_run_enable)
                      || GUARD.first_ext_wake_enable || GUARD.second_ext_wake_enable
                      || (GUARD.watchdog_period_nonzero && !GUARD.watchdog_steering);
  wire sleep_allowed = !GUARD.clock_halt && wake_enabled && !GUARD.irq_pending
                       && !wake_trigger;
  wire req_take = req_write && sleep_allowed && (state == HSPC_RUN) && pv_sync;

  // ****************************************
  // Free-running tick divider
  // ****************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tick_div <= 32'h0;
    end else if (tick) begin
      tick_div <= 32'h0;
    end else begin
      tick_div <= tick_div + 32'h1;
    end
  end

  assign tick = (tick_div == 32'(TICK_CYCLES_P - 1));

  // ****************************************
  // State machine
  // ****************************************
  // Counter stays free of the request phase, hence the N-1 to N window
  wire sleep_expiry = (delay_count == 3'h0);

  always_comb begin
    next_state = state;
    case (state)
      HSPC_RUN: begin
        if (req_take) begin
          next_state = (new_timeout == 3'h0) ? HSPC_SLEEP : HSPC_WAIT;
        end
      end
      HSPC_WAIT: begin
        if (wake_trigger) begin
          next_state = HSPC_RUN;
        end else if (sleep_expiry) begin
          next_state = HSPC_SLEEP;
        end
      end
      HSPC_SLEEP: begin
        if (wake_trigger) begin
          next_state = HSPC_RUN;
        end
      end
      default: begin
        next_state = HSPC_RUN;
      end
    endcase
    if (!pv_sync) begin
      next_state = HSPC_RUN;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= HSPC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Delay counter
  // ****************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      delay_count <= 3'h0;
    end else if (req_take) begin
      delay_count <= new_timeout;
    end else if (state == HSPC_WAIT && tick && delay_count != 3'h0) begin
      delay_count <= delay_count - 3'h1;
    end
  end

  // ****************************************
  // Sleep control register
  // ****************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      {sleep_request, sleep_reset_enable, ext2_edge_polarity, ext1_edge_polarity,
       sleep_occurred_flag, sleep_timeout_count} <= SLEEP_CONTROL_RESET;
    end else begin
      if (reg_hit) begin
        sleep_reset_enable <= REG_WDATA[SLEEP_RESET_ENABLE_BIT];
        ext2_edge_polarity <= REG_WDATA[EXT2_EDGE_POLARITY_BIT];
        ext1_edge_polarity <= REG_WDATA[EXT1_EDGE_POLARITY_BIT];
        sleep_timeout_count <= new_timeout;
      end
      if (next_state == HSPC_RUN) begin
        sleep_request <= 1'b0;
      end else if (req_take) begin
        sleep_request <= 1'b1;
      end
      // Entry into sleep wins over a software clear in the same cycle
      if (next_state == HSPC_SLEEP && state != HSPC_SLEEP) begin
        sleep_occurred_flag <= 1'b1;
      end else if (flag_write_clear) begin
        sleep_occurred_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= {sleep_request, sleep_reset_enable, ext2_edge_polarity, ext1_edge_polarity,
                    sleep_occurred_flag, sleep_timeout_count};
    end
  end

  // ****************************************
  // Host outputs
  // ****************************************
  wire in_sleep = (state == HSPC_SLEEP);
  wire pin2_sleep_mode = (PIN2_OUTPUT_SELECT == PIN2_SELECT_SLEEP);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      HOST_RESET_N <= 1'b1;
      HOST_POWER_SIGNAL <= 1'b1;
      POWER_SWITCH_PIN_O <= 1'b0;
      POWER_SWITCH_PIN_OE <= 1'b1;
      FIRST_EXTERNAL_IRQ <= 1'b0;
      SECOND_EXTERNAL_IRQ <= 1'b0;
    end else begin
      HOST_RESET_N <= !(in_sleep && sleep_reset_enable);
      HOST_POWER_SIGNAL <= !in_sleep;
      FIRST_EXTERNAL_IRQ <= ext1_edge;
      SECOND_EXTERNAL_IRQ <= ext2_edge;
      if (pin2_sleep_mode && LOW_RES_SWITCH_ENABLE) begin
        POWER_SWITCH_PIN_O <= 1'b0;
        POWER_SWITCH_PIN_OE <= !in_sleep;
      end else if (pin2_sleep_mode) begin
        POWER_SWITCH_PIN_O <= in_sleep;
        POWER_SWITCH_PIN_OE <= 1'b1;
      end else begin
        POWER_SWITCH_PIN_O <= STATIC_OUT_BIT;
        POWER_SWITCH_PIN_OE <= 1'b1;
      end
    end
  end

  assign SLEEP_STATE = state;

endmodule
`default_nettype wire

// ### verification/hspc_checker.sv
// Concurrent assertions on the ports of the host sleep power control block
`timescale 1ns/1ps
`default_nettype none
module hspc_checker
  import hspc_pkg::*;
(
  // Clock and register port
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REG_WRITE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Configuration and sources
  input wire hspc_guard_s GUARD,
  input wire hspc_irq_s IRQ,
  input wire logic [2:0] PIN2_OUTPUT_SELECT,
  input wire logic LOW_RES_SWITCH_ENABLE,
  // Host pins
  input wire logic HOST_RESET_N,
  input wire logic HOST_POWER_SIGNAL,
  input wire logic POWER_SWITCH_PIN_O,
  input wire logic POWER_SWITCH_PIN_OE,
  input wire logic [1:0] SLEEP_STATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire req_wr = REG_WRITE && REG_ADDR == 8'h17 && REG_WDATA[7] && SLEEP_STATE == 2'b00;
  wire wake_ok = GUARD.alarm_irq_enable || (GUARD.countdown_irq_enable && GUARD.countdown_run_enable) ||
    GUARD.first_ext_wake_enable || GUARD.second_ext_wake_enable ||
    (GUARD.watchdog_period_nonzero && !GUARD.watchdog_steering);
  wire od_mode = PIN2_OUTPUT_SELECT == 3'h6 && LOW_RES_SWITCH_ENABLE;

  AST_RUN_HOST_ON: assert property (SLEEP_STATE != 2'b11 |=> HOST_POWER_SIGNAL && HOST_RESET_N)
    else $error("host power or reset wrong outside sleep");
  AST_SLEEP_POWER_OFF: assert property (SLEEP_STATE == 2'b11 |=> !HOST_POWER_SIGNAL)
    else $error("host power still on in sleep");
  AST_SLEEP_RESET: assert property ((SLEEP_STATE == 2'b11) [*2] |=> HOST_RESET_N != REG_RDATA[6])
    else $error("host reset does not follow its enable in sleep");
  AST_REQ_MIRRORS_STATE: assert property (REG_RDATA[7] == ($past(SLEEP_STATE) != 2'b00))
    else $error("sleep request bit disagrees with state");
  AST_REFUSE_HALT: assert property (req_wr && GUARD.clock_halt |=> SLEEP_STATE == 2'b00)
    else $error("request taken with clock halted");
  AST_REFUSE_PENDING: assert property (req_wr && GUARD.irq_pending |=> SLEEP_STATE == 2'b00)
    else $error("request taken with interrupt pending");
  AST_REFUSE_NO_WAKE: assert property (req_wr && !wake_ok |=> SLEEP_STATE == 2'b00)
    else $error("request taken with no wake source");
  AST_ZERO_TIMEOUT: assert property (req_wr && REG_WDATA[2:0] == 3'h0 && GUARD == 9'h080 && IRQ == 6'h00
    |=> SLEEP_STATE == 2'b11)
    else $error("zero timeout did not sleep at once");
  AST_WAKE: assert property (SLEEP_STATE != 2'b00 && IRQ != 6'h00 |=> SLEEP_STATE == 2'b00)
    else $error("wake request did not return to run");
  AST_OPEN_DRAIN: assert property (od_mode |=> !POWER_SWITCH_PIN_O &&
    POWER_SWITCH_PIN_OE == ($past(SLEEP_STATE) != 2'b11))
    else $error("power switch wrong in open drain mode");
  AST_SLEEP_INDICATION: assert property (PIN2_OUTPUT_SELECT == 3'h6 && !LOW_RES_SWITCH_ENABLE
    |=> POWER_SWITCH_PIN_O == ($past(SLEEP_STATE) == 2'b11))
    else $error("sleep indication wrong");

  CVR_WAIT_SLEEP: cover property (SLEEP_STATE == 2'b01 ##1 SLEEP_STATE == 2'b11);
  CVR_WAIT_ABORT: cover property (SLEEP_STATE == 2'b01 ##1 SLEEP_STATE == 2'b00);
  CVR_SLEEP_WAKE: cover property (SLEEP_STATE == 2'b11 ##1 SLEEP_STATE == 2'b00);
endmodule

bind hspc_top hspc_checker u_hspc_checker (.CLK, .RESET, .REG_WRITE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
  .GUARD, .IRQ, .PIN2_OUTPUT_SELECT, .LOW_RES_SWITCH_ENABLE, .HOST_RESET_N, .HOST_POWER_SIGNAL,
  .POWER_SWITCH_PIN_O, .POWER_SWITCH_PIN_OE, .SLEEP_STATE);
`default_nettype wire

// ### verification/hspc_host_model.sv
// Behavioural host controller powered and reset through the sleep pins
`timescale 1ns/1ps
`default_nettype none
module hspc_host_model (
  // Pins from the device
  input wire logic psw_o,
  input wire logic psw_oe,
  input wire logic host_reset_n,
  // Host condition
  output logic host_up,
  output logic interface_gate
);
  // Ground return exists only while the switch pulls low
  wire grounded = psw_oe && !psw_o;
  assign host_up = grounded && host_reset_n;
  // An unpowered host floats the bus, so the gate closes
  assign interface_gate = !grounded;
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench for the host sleep power control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hspc_pkg::*;
  // Short tick keeps the delay scenarios brief
  localparam int TK = 16;
  logic clk = 1'b0, rst = 1'b1, pv = 1'b1, wr = 1'b0, lrs = 1'b0, ext_input_pin = 1'b0, watchdog_input_pin = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd;
  logic [2:0] p2sel = 3'h7;
  hspc_guard_s guard = '0;
  hspc_irq_s irq = '0;
  logic x1, x2, hrn, hps, pso, psoe, up, gate;
  logic sob = 1'b0;
  logic [1:0] st;
  int err_total = 0;
  int checks = 0;
  always #2 clk = ~clk;
  hspc_top #(.TICK_CYCLES_P(TK)) u_hspc_top (.CLK(clk), .RESET(rst), .POWER_VALID(pv), .REG_WRITE(wr),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rd), .GUARD(guard), .PIN2_OUTPUT_SELECT(p2sel),
    .LOW_RES_SWITCH_ENABLE(lrs), .STATIC_OUT_BIT(sob), .IRQ(irq), .EXT_INPUT_PIN(ext_input_pin),
    .WATCHDOG_INPUT_PIN(watchdog_input_pin), .FIRST_EXTERNAL_IRQ(x1), .SECOND_EXTERNAL_IRQ(x2), .HOST_RESET_N(hrn),
    .HOST_POWER_SIGNAL(hps), .POWER_SWITCH_PIN_O(pso), .POWER_SWITCH_PIN_OE(psoe), .SLEEP_STATE(st));
  hspc_host_model u_hspc_host_model (.psw_o(pso), .psw_oe(psoe), .host_reset_n(hrn), .host_up(up),
    .interface_gate(gate));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic wait_st(input logic [1:0] s, input int lim, output int n);
    n = 0;
    while (st !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk({6'h0, st}, {6'h0, s});
    if (st !== s) wrap_up();
  endtask
  task automatic wake(input hspc_irq_s v);
    @(negedge clk);
    irq = v;
    @(negedge clk);
    irq = '0;
  endtask

  // Five qualifying wake setups, then five that must be refused
  task automatic t_guard();
    logic [8:0] g [10] = '{9'h080, 9'h060, 9'h010, 9'h008, 9'h004, 9'h040, 9'h006, 9'h180, 9'h081, 9'h000};
    for (int i = 0; i < 10; i++) begin
      guard = g[i];
      wr_reg(8'h17, 8'h80);
      cyc(2);
      chk(rd, (i < 5) ? 8'h88 : 8'h00);
      if (i < 5) begin
        chk({7'h0, hps}, 8'h00);
        wake(6'h20);
        cyc(2);
        chk(rd, 8'h08);
      end
    end
    guard = 9'h080;
    wr_reg(8'h16, 8'h80);
    cyc(2);
    chk({6'h0, st}, 8'h00);
    $display("guard test done");
  endtask
  task automatic t_delay(input int n);
    int c;
    guard = 9'h080;
    wr_reg(8'h17, 8'h80 | 8'(n));
    wait_st(2'b11, 8 * TK + 8, c);
    chk(8'(c >= (n - 1) * TK - 2 && c <= n * TK + 2), 8'h01);
    wake(6'h01);
    $display("delay %0d test done", n);
  endtask
  task automatic t_wait_wake();
    for (int b = 0; b < 6; b++) begin
      wr_reg(8'h17, 8'h87);
      cyc(5);
      chk({6'h0, st}, 8'h01);
      wake(6'h01 << b);
      chk({6'h0, st}, 8'h00);
      cyc(2);
      chk(rd & 8'h80, 8'h00);
    end
    $display("wait wake test done");
  endtask
  task automatic t_switch();
    logic m;
    sob = 1'b1;
    cyc(3);
    chk({7'h0, pso}, 8'h01);
    sob = 1'b0;
    cyc(3);
    chk({7'h0, pso}, 8'h00);
    p2sel = 3'h6;
    for (int k = 0; k < 2; k++) begin
      m = k[0];
      lrs = m;
      wr_reg(8'h17, 8'hC0);
      cyc(3);
      chk({4'h0, hrn, hps, pso, up}, {6'h0, !m, 1'b0});
      chk({7'h0, gate}, 8'h01);
      wake(6'h02);
      cyc(3);
      chk({4'h0, hrn, hps, pso, up & m}, {7'h6, m});
      chk({7'h0, gate}, 8'h00);
    end
    p2sel = 3'h7;
    $display("switch test done");
  endtask
  // Bit 0 of k picks the edge, bit 1 the polarity, bit 2 the pin
  task automatic t_edges();
    int cnt;
    guard = '0;
    for (int k = 0; k < 8; k++) begin
      wr_reg(8'h17, k[1] ? (k[2] ? 8'h20 : 8'h10) : 8'h00);
      ext_input_pin = !k[0];
      watchdog_input_pin = !k[0];
      cyc(8);
      if (k[2]) watchdog_input_pin = k[0];
      else ext_input_pin = k[0];
      cnt = 0;
      repeat (8) begin
        @(negedge clk);
        cnt += ((k[2] ? x2 : x1) === 1'b1);
      end
      chk(8'(cnt), {7'h0, k[0] == k[1]});
    end
    $display("edge test done");
  endtask
  task automatic t_power();
    guard = 9'h080;
    wr_reg(8'h17, 8'h87);
    cyc(3);
    pv = 1'b0;
    cyc(5);
    chk({hrn, hps, 4'h0, st}, 8'hC0);
    chk(rd & 8'h80, 8'h00);
    pv = 1'b1;
    cyc(4);
    $display("power test done");
  endtask

  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(3);
    chk(rd, 8'h00);
    chk({hrn, hps, 4'h0, st}, 8'hC0);
    t_guard();
    t_delay(3);
    t_delay(1);
    t_delay(7);
    t_wait_wake();
    t_switch();
    t_edges();
    t_power();
    wrap_up();
  end
endmodule
`default_nettype wire
